// file: testbench/uio_props.sv
// Concurrent checks on the link, frame pulse, interrupt and staging stream.
// Assumes one clock domain and instantiation beside the link interface.
`timescale 1ns/10ps
module uio_props #(
	parameter int FRAME_CYC = 200
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	input wire logic sof,
	input wire logic pkt_valid,
	input wire logic pkt_last,
	// Endpoint events
	input wire logic ep_irq,
	input wire logic frame_pulse,
	// Staging stream
	input wire logic stage_valid,
	input wire logic stage_ready,
	input wire logic [7:0] stage_data,
	input wire logic stage_last,
	input wire logic stage_eop,
	input wire logic stage_empty,
	input wire logic stage_full,
	input wire logic pkt_posted
);
	logic eop_take;
	int gap_cnt;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Packet end leaving the staging stream
	assign eop_take = stage_valid & stage_ready & stage_eop;
	// Cycles since last frame pulse; a lost frame start must not stretch it
	always_ff @(posedge aclk) begin
		if (!aresetn || frame_pulse) begin
			gap_cnt <= 0;
		end else begin
			gap_cnt <= gap_cnt + 1;
		end
	end
	chk_pulse_after_sof: assert property (sof |=> frame_pulse)
		else $error("frame pulse missing after frame start");
	chk_pulse_spacing: assert property (frame_pulse |=> !frame_pulse [*8])
		else $error("frame pulses too close");
	chk_pulse_gap: assert property (gap_cnt <= FRAME_CYC + 2)
		else $error("frame pulse overdue");
	chk_irq_cause: assert property (ep_irq |-> $past(pkt_valid))
		else $error("endpoint interrupt without packet byte");
	chk_posted_eop: assert property (pkt_posted |-> $past(eop_take))
		else $error("packet posted without end byte drained");
	chk_eop_closes: assert property (stage_valid && stage_eop |-> stage_last)
		else $error("packet end does not close bank");
	chk_stage_hold: assert property (stage_valid && !stage_ready |=>
		stage_valid && $stable(stage_data))
		else $error("staging byte changed while stalled");
	chk_bank_flags: assert property (!(stage_empty && (stage_full || stage_valid)))
		else $error("staging flags inconsistent");
	chk_pkt_span: assert property (pkt_valid && !pkt_last |=> pkt_valid)
		else $error("gap inside packet");
	chk_sof_width: assert property (sof |=> !sof)
		else $error("frame start longer than one cycle");
endmodule // uio_props

// file: testbench/usb_iso_out_endpoint_dma_tb_top.sv
// Self-checking bench: host end and endpoint joined by the link interface.
// Assumes short frame parameters; bench is AXI4-Lite master and stream sink.
`timescale 1ns/10ps
`include "uio_params.svh"
module usb_iso_out_endpoint_dma_tb_top;
	localparam int FC = 200;
	localparam int UC = 100;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
	logic rready = 0, stage_ready = 0, req_valid = 0, req_crc_err = 0, high_speed = 0;
	logic awready, wready, bvalid, arready, rvalid, ep_irq, frame_pulse, dma_req;
	logic stage_valid, stage_last, stage_eop, stage_empty, stage_full, pkt_posted, req_ready;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata;
	logic [3:0] wstrb = 4'hf;
	logic [1:0] bresp, rresp;
	logic [7:0] stage_data, req_seed = 0;
	logic [10:0] req_len = 0;
	logic [31:0] ctl;
	int error_cnt = 0, compares = 0, irq_cnt = 0, fp_cnt = 0, post_cnt = 0, bpos = 0;
	int mq[$];
	int lq[$];
	uio_link_if link();
	uio_host #(.FRAME_CYC(FC), .UFRAME_CYC(UC)) i_uio_host (.aclk(aclk), .aresetn(aresetn),
		.link(link), .req_valid(req_valid), .req_ready(req_ready), .req_len(req_len),
		.req_seed(req_seed), .req_crc_err(req_crc_err), .high_speed(high_speed));
	uio_device #(.FRAME_CYC(FC), .UFRAME_CYC(UC)) i_uio_device (.aclk(aclk),
		.aresetn(aresetn), .link(link), .s_awaddr(awaddr), .s_awvalid(awvalid),
		.s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
		.s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
		.s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
		.s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .ep_irq(ep_irq),
		.frame_pulse(frame_pulse), .dma_req(dma_req), .stage_valid(stage_valid),
		.stage_ready(stage_ready), .stage_data(stage_data), .stage_last(stage_last),
		.stage_eop(stage_eop), .stage_empty(stage_empty), .stage_full(stage_full),
		.pkt_posted(pkt_posted));
	uio_props #(.FRAME_CYC(FC)) i_uio_props (.aclk(aclk), .aresetn(aresetn), .sof(link.sof),
		.pkt_valid(link.pkt_valid), .pkt_last(link.pkt_last), .ep_irq(ep_irq),
		.frame_pulse(frame_pulse), .stage_valid(stage_valid), .stage_ready(stage_ready),
		.stage_data(stage_data), .stage_last(stage_last), .stage_eop(stage_eop),
		.stage_empty(stage_empty), .stage_full(stage_full), .pkt_posted(pkt_posted));
	// 20 MHz clock
	always #25 aclk = ~aclk;
	// Event counters and staging sink with random stalls
	always @(posedge aclk) begin
		if (ep_irq === 1'b1) irq_cnt++;
		if (frame_pulse === 1'b1) fp_cnt++;
		if (pkt_posted === 1'b1) post_cnt++;
		if (stage_valid === 1'b1 && stage_ready === 1'b1) begin
			check(stage_last, mq.size() == 1 || bpos == `UIO_STAGE_BYTES - 1);
			bpos = (mq.size() == 1 || bpos == `UIO_STAGE_BYTES - 1) ? 0 : bpos + 1;
			check(stage_eop, mq.size() == 1);
			check(stage_data, mq.pop_front());
		end
		stage_ready <= 1'($urandom);
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic done;
		done = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!done) begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
			done = bvalid;
		end
		bready <= 0;
		check(bresp, `UIO_RESP_OKAY);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!done) begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
			done = rvalid;
			d = rdata;
			r = rresp;
		end
		rready <= 0;
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(d, exp);
	endtask
	// One host packet; the model keeps it only when the endpoint should accept it
	task automatic send(input int len, input logic crc, input bit push);
		logic [7:0] s;
		s = 8'($urandom);
		@(posedge aclk);
		req_len <= len[10:0];
		req_seed <= s;
		req_crc_err <= crc;
		req_valid <= 1;
		do @(posedge aclk); while (!req_ready);
		req_valid <= 0;
		do @(posedge aclk); while (!(link.pkt_valid && link.pkt_last));
		if (push) begin
			lq.push_back(len);
			for (int i = 0; i < len; i++) mq.push_back((s + i) & 255);
		end
		repeat (2) @(negedge aclk);
	endtask
	// Software unload of the head packet, then release of its slot
	task automatic drain();
		int n;
		n = lq.pop_front();
		rchk(`UIO_OFS_COUNT, n);
		repeat (n) rchk(`UIO_OFS_DATA, mq.pop_front());
		wr(`UIO_OFS_CTRL, ctl);
	endtask
	initial begin
		int k;
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(16));
		repeat (20) @(posedge aclk);
		aresetn <= 1;
		rchk(`UIO_OFS_CTRL, `UIO_RST_CTRL);
		rd(12'h020, d, r);
		check(r, `UIO_RESP_SLVERR);
		send(20, 0, 0);
		rchk(`UIO_OFS_CTRL, 0);
		wr(`UIO_OFS_MAXP, 80);
		wr(`UIO_OFS_IRQ_EN, 1 << `UIO_EP_NUM);
		ctl = 32'h0000_5000; // Suppress bit set but must be ignored; mode bit stays 0
		wr(`UIO_OFS_CTRL, ctl);
		rchk(`UIO_OFS_CTRL, ctl);
		k = irq_cnt;
		send(1 + $urandom % 80, 0, 1);
		rchk(`UIO_OFS_CTRL, 32'h0000_5001);
		check(irq_cnt, k + 1);
		send(20, 0, 0);
		rchk(`UIO_OFS_CTRL, 32'h0000_5005);
		check(irq_cnt, k + 2);
		drain();
		rchk(`UIO_OFS_CTRL, ctl);
		send(1 + $urandom % 80, 1, 1);
		rchk(`UIO_OFS_CTRL, 32'h0000_5009);
		drain();
		wr(`UIO_OFS_SIZING, 32'h0000_0010);
		send(1 + $urandom % 80, 0, 1);
		send(1 + $urandom % 80, 0, 1);
		rchk(`UIO_OFS_CTRL, 32'h0000_5001);
		drain();
		drain();
		rchk(`UIO_OFS_CTRL, ctl);
		ctl = 32'h0000_6000;
		wr(`UIO_OFS_CTRL, ctl);
		k = irq_cnt;
		for (int i = 0; i < 3; i++) begin
			send(i == 0 ? 64 : 65 + $urandom % 16, i == 2, 1);
			check(dma_req, 1);
			lq.delete();
			while (mq.size() != 0) @(posedge aclk);
			repeat (3) @(negedge aclk);
			check(dma_req, 0);
			check(stage_empty, 1);
		end
		check(irq_cnt, k + 1);
		check(post_cnt, 3);
		k = fp_cnt;
		repeat (5 * FC) @(posedge aclk);
		check(fp_cnt - k, 5);
		high_speed <= 1;
		wr(`UIO_OFS_FRAME_CTL, 1);
		repeat (FC + 2 * UC) @(posedge aclk);
		k = fp_cnt;
		repeat (4 * UC) @(posedge aclk);
		check(fp_cnt - k, 4);
		// Host back to full frames while the endpoint expects microframes:
		// every other start is missing and the counter must fill it in
		high_speed <= 0;
		repeat (2 * FC) @(posedge aclk);
		k = fp_cnt;
		repeat (4 * FC) @(posedge aclk);
		check(fp_cnt - k, 8);
		print_verdict();
	end
	// Hang guard, well beyond the expected run length
	initial begin
		repeat (30000) @(posedge aclk);
		error_cnt++;
		print_verdict();
	end
endmodule // usb_iso_out_endpoint_dma_tb_top

// file: verilog/uio_device.sv
// Isochronous OUT endpoint: packet FIFO, frame pulse, DMA staging.
// Assumes an AXI4-Lite master and the link partner share aclk.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "uio_params.svh"
module uio_device #(
	parameter int MAX_PKT = `UIO_MAX_PKT,
	parameter int STAGE_BYTES = `UIO_STAGE_BYTES,
	parameter int EP_NUM = `UIO_EP_NUM,
	parameter int FRAME_CYC = `UIO_FRAME_CYC,
	parameter int UFRAME_CYC = `UIO_UFRAME_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	uio_link_if.dev link,
	// AXI4-Lite slave
	input wire logic [11:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [11:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Endpoint events
	output logic ep_irq,
	output logic frame_pulse,
	output logic dma_req,
	// Staging drain stream
	output logic stage_valid,
	input wire logic stage_ready,
	output logic [7:0] stage_data,
	output logic stage_last,
	output logic stage_eop,
	output logic stage_empty,
	output logic stage_full,
	output logic pkt_posted
);
	localparam int AW = $clog2(MAX_PKT);
	localparam int SW = $clog2(STAGE_BYTES);

	// Only data endpoints 1 to 4 own a DMA port
	generate
		if (EP_NUM < 1 || EP_NUM > 4) begin : g_bad_ep
			$error("uio_device: endpoint must be 1 to 4");
		end
		if (MAX_PKT < 8 || MAX_PKT > 1024 || (MAX_PKT & (MAX_PKT - 1)) != 0) begin : g_bad_pkt
			$error("uio_device: packet size must be a power of two up to 1024");
		end
		if (STAGE_BYTES < 4 || (STAGE_BYTES & (STAGE_BYTES - 1)) != 0) begin : g_bad_stg
			$error("uio_device: staging bank must be a power of two");
		end
	endgenerate

	// Registers and endpoint state
	logic [15:0] ctrl;
	logic dbl;
	logic [10:0] maxp;
	logic [4:0] irq_en;
	logic high_speed;
	logic [10:0] frame_num;
	logic overrun;
	logic [7:0] mem [2*MAX_PKT];
	logic [10:0] slot_len [2];
	logic slot_err [2];
	logic wr_slot, rd_slot;
	logic [1:0] nfull;
	logic [10:0] wr_cnt, rd_ptr;
	logic in_pkt, in_take, in_trunc;
	logic aw_hold, w_hold;
	logic [11:0] aw_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic do_write, do_read, wr_ctrl, sw_clear, sw_pop;
	logic pkt_start, drop, complete, release_slot, xfer, xfer_last;
	logic [31:0] fcnt, period;
	logic [7:0] stage [2*STAGE_BYTES];
	logic [1:0] stg_full, stg_eop;
	logic [SW:0] stg_len [2];
	logic wb, rb;
	logic [SW:0] sp, rp;
	logic [10:0] limit;

	logic iso_sel, dma_en;
	assign iso_sel = ctrl[`UIO_BIT_ISO];
	assign dma_en = ctrl[`UIO_BIT_DMA_EN];
	// Handshake suppress and DMA mode bits are stored only; no logic reads them

	// Write path: address and data taken in either order
	assign s_awready = !aw_hold;
	assign s_wready = !w_hold;
	assign do_write = aw_hold && w_hold && !s_bvalid;
	assign wr_ctrl = do_write && aw_q == `UIO_OFS_CTRL;
	assign sw_clear = wr_ctrl && ws_q[0] && !wd_q[`UIO_BIT_PKT_READY] && nfull != 2'd0;
	assign s_arready = !s_rvalid;
	assign do_read = s_arvalid && s_arready;
	assign sw_pop = do_read && s_araddr == `UIO_OFS_DATA && nfull != 2'd0 && !dma_en;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_q <= 12'h000;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
			s_bvalid <= 1'b0;
			s_bresp <= `UIO_RESP_OKAY;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_hold <= 1'b1;
				aw_q <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_hold <= 1'b1;
				wd_q <= s_wdata;
				ws_q <= s_wstrb;
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (aw_q > `UIO_OFS_FRAME_NUM || aw_q[1:0] != 2'h0) ?
					`UIO_RESP_SLVERR : `UIO_RESP_OKAY;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end

	// Software-written configuration, byte lane 0 and 1 honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `UIO_RST_CTRL;
			dbl <= 1'b0;
			maxp <= `UIO_RST_MAXP;
			irq_en <= 5'h00;
			high_speed <= 1'b0;
		end else if (do_write) begin
			case (aw_q)
				`UIO_OFS_CTRL: begin
					if (ws_q[1]) ctrl[15:11] <= wd_q[15:11];
				end
				`UIO_OFS_SIZING: begin
					if (ws_q[0]) dbl <= wd_q[`UIO_BIT_DOUBLE_BUF];
				end
				`UIO_OFS_MAXP: begin
					if (ws_q[0]) maxp[7:0] <= wd_q[7:0];
					if (ws_q[1]) maxp[10:8] <= wd_q[10:8];
				end
				`UIO_OFS_IRQ_EN: begin
					if (ws_q[0]) irq_en <= wd_q[4:0];
				end
				`UIO_OFS_FRAME_CTL: begin
					if (ws_q[0]) high_speed <= wd_q[`UIO_BIT_HIGH_SPEED];
				end
				default: begin
				end
			endcase
		end
	end

	// Read path; reading the data register pops one byte unless DMA is enabled
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0000_0000;
			s_rresp <= `UIO_RESP_OKAY;
		end else if (do_read) begin
			s_rvalid <= 1'b1;
			s_rresp <= `UIO_RESP_OKAY;
			s_rdata <= 32'h0000_0000;
			case (s_araddr)
				`UIO_OFS_CTRL: s_rdata <= {16'h0000, ctrl[15:11], 7'h00,
					(nfull != 2'd0) && slot_err[rd_slot], 1'b0 ^ overrun, 1'b0,
					nfull != 2'd0};
				`UIO_OFS_SIZING: s_rdata <= {27'h0, dbl, 4'h0};
				`UIO_OFS_MAXP: s_rdata <= {21'h0, maxp};
				`UIO_OFS_IRQ_EN: s_rdata <= {27'h0, irq_en};
				`UIO_OFS_DATA: s_rdata <= {24'h0, mem[{rd_slot, rd_ptr[AW-1:0]}]};
				`UIO_OFS_COUNT: s_rdata <= {21'h0, nfull != 2'd0 ? slot_len[rd_slot] : 11'h0};
				`UIO_OFS_FRAME_CTL: s_rdata <= {31'h0, high_speed};
				`UIO_OFS_FRAME_NUM: s_rdata <= {21'h0, frame_num};
				default: s_rresp <= `UIO_RESP_SLVERR;
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end

	// Packet arrival: accept only with a free slot, else drop whole packet
	assign pkt_start = link.pkt_valid && !in_pkt && iso_sel;
	assign drop = pkt_start && nfull >= (dbl ? 2'd2 : 2'd1);
	assign complete = link.pkt_valid && link.pkt_last && (in_take || (pkt_start && !drop));
	assign limit = (maxp == 11'h0 || maxp > 11'(MAX_PKT)) ? 11'(MAX_PKT) : maxp;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			in_pkt <= 1'b0;
			in_take <= 1'b0;
			in_trunc <= 1'b0;
			wr_cnt <= 11'h000;
			wr_slot <= 1'b0;
			slot_len[0] <= 11'h000;
			slot_len[1] <= 11'h000;
			slot_err[0] <= 1'b0;
			slot_err[1] <= 1'b0;
		end else if (link.pkt_valid) begin
			in_pkt <= !link.pkt_last;
			if (pkt_start) begin
				in_take <= !drop && !link.pkt_last;
			end else if (link.pkt_last) begin
				in_take <= 1'b0;
			end
			if (in_take || (pkt_start && !drop)) begin
				// Oversize bytes are discarded and flagged as a data error
				if (wr_cnt < limit) begin
					mem[{wr_slot, wr_cnt[AW-1:0]}] <= link.pkt_data;
				end
				if (link.pkt_last) begin
					slot_len[wr_slot] <= (wr_cnt < limit) ? wr_cnt + 11'h001 : limit;
					slot_err[wr_slot] <= link.pkt_crc_err || in_trunc || wr_cnt >= limit;
					wr_slot <= wr_slot ^ dbl;
					wr_cnt <= 11'h000;
					in_trunc <= 1'b0;
				end else begin
					in_trunc <= in_trunc || wr_cnt >= limit;
					wr_cnt <= (wr_cnt < limit) ? wr_cnt + 11'h001 : wr_cnt;
				end
			end
		end
	end

	// Slot accounting; a new packet and a release in one cycle both count
	assign release_slot = sw_clear || (xfer && xfer_last) ||
		(dma_req && slot_len[rd_slot] == 11'h000);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nfull <= 2'd0;
			rd_slot <= 1'b0;
			rd_ptr <= 11'h000;
		end else begin
			nfull <= nfull + {1'b0, complete} - {1'b0, release_slot};
			if (release_slot) begin
				rd_slot <= rd_slot ^ dbl;
				rd_ptr <= 11'h000;
			end else if (sw_pop || xfer) begin
				rd_ptr <= rd_ptr + 11'h001;
			end
		end
	end

	// Overrun is sticky; the setting event wins over a clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overrun <= 1'b0;
			ep_irq <= 1'b0;
		end else begin
			overrun <= drop || (overrun && !(wr_ctrl && ws_q[0] && !wd_q[`UIO_BIT_OVERRUN]));
			ep_irq <= irq_en[EP_NUM] && (drop ||
				(complete && (!dma_en || link.pkt_crc_err)));
		end
	end

	// Frame pulse on start of frame, or by the counter when one is lost
	// Counter waits one cycle past the period so an on-time start wins,
	// and >= copes with a period that shrinks under a running count
	assign period = high_speed ? UFRAME_CYC : FRAME_CYC;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fcnt <= 32'h0000_0000;
			frame_pulse <= 1'b0;
			frame_num <= 11'h000;
		end else begin
			frame_pulse <= link.sof || fcnt >= period;
			fcnt <= (link.sof || fcnt >= period) ? 32'h0000_0000 : fcnt + 32'h0000_0001;
			if (link.sof) begin
				frame_num <= link.frame_num;
			end
		end
	end

	// Transfer DMA moves head packet bytes into the free staging bank
	assign dma_req = dma_en && iso_sel && nfull != 2'd0;
	assign xfer = dma_req && !stg_full[wb] && slot_len[rd_slot] != 11'h000;
	assign xfer_last = rd_ptr + 11'h001 == slot_len[rd_slot];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wb <= 1'b0;
			sp <= '0;
			stg_len[0] <= '0;
			stg_len[1] <= '0;
			stg_eop <= 2'b00;
		end else if (xfer) begin
			stage[{wb, sp[SW-1:0]}] <= mem[{rd_slot, rd_ptr[AW-1:0]}];
			if (xfer_last || sp == (SW+1)'(STAGE_BYTES - 1)) begin
				stg_len[wb] <= sp + (SW+1)'(1);
				stg_eop[wb] <= xfer_last;
				wb <= !wb;
				sp <= '0;
			end else begin
				sp <= sp + (SW+1)'(1);
			end
		end
	end

	// Ping-pong banks: one fills while the other drains
	assign stage_valid = stg_full[rb];
	assign stage_data = stage[{rb, rp[SW-1:0]}];
	assign stage_last = rp + (SW+1)'(1) == stg_len[rb];
	assign stage_eop = stage_last && stg_eop[rb];
	assign stage_empty = stg_full == 2'b00;
	assign stage_full = stg_full == 2'b11;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stg_full <= 2'b00;
			rb <= 1'b0;
			rp <= '0;
			pkt_posted <= 1'b0;
		end else begin
			pkt_posted <= stage_valid && stage_ready && stage_eop;
			if (xfer && (xfer_last || sp == (SW+1)'(STAGE_BYTES - 1))) begin
				stg_full[wb] <= 1'b1;
			end
			if (stage_valid && stage_ready) begin
				if (stage_last) begin
					stg_full[rb] <= 1'b0;
					rb <= !rb;
					rp <= '0;
				end else begin
					rp <= rp + (SW+1)'(1);
				end
			end
		end
	end
endmodule // uio_device

// file: verilog/uio_host.sv
// USB host end: emits frame starts and at most one ordered OUT packet per frame.
// Assumes the user supplies packet orders; payload is a counting pattern.
`timescale 1ns/10ps
`include "uio_params.svh"
module uio_host #(
	parameter int FRAME_CYC = `UIO_FRAME_CYC,
	parameter int UFRAME_CYC = `UIO_UFRAME_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link
	uio_link_if.hst link,
	// Packet orders
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [10:0] req_len,
	input wire logic [7:0] req_seed,
	input wire logic req_crc_err,
	input wire logic high_speed
);
	generate
		if (FRAME_CYC < 64 || UFRAME_CYC < 64) begin : g_bad
			$error("uio_host: frame too short");
		end
	endgenerate

	uio_pkg::uio_host_state_e state;
	logic [31:0] fcnt;
	logic [31:0] period;
	logic sent_this_frame;
	logic [10:0] left;
	logic frame_end;

	// One period per frame or microframe
	assign period = high_speed ? UFRAME_CYC : FRAME_CYC;
	assign frame_end = (fcnt >= period - 1);
	// Only one packet per frame; never in the last cycle of a frame
	assign req_ready = (state == uio_pkg::UIO_H_IDLE) && !sent_this_frame && !frame_end;

	// Frame timer and start-of-frame marker
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fcnt <= 32'h0000_0000;
			link.sof <= 1'b0;
			link.frame_num <= 11'h000;
		end else begin
			fcnt <= frame_end ? 32'h0000_0000 : fcnt + 32'h0000_0001;
			link.sof <= frame_end;
			if (frame_end) begin
				link.frame_num <= link.frame_num + 11'h001;
			end
		end
	end

	// Packet sender
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= uio_pkg::UIO_H_IDLE;
			sent_this_frame <= 1'b0;
			left <= 11'h000;
			link.pkt_valid <= 1'b0;
			link.pkt_data <= 8'h00;
			link.pkt_last <= 1'b0;
			link.pkt_crc_err <= 1'b0;
		end else begin
			if (frame_end) begin
				sent_this_frame <= 1'b0;
			end
			case (state)
				uio_pkg::UIO_H_IDLE: begin
					link.pkt_valid <= 1'b0;
					link.pkt_last <= 1'b0;
					link.pkt_crc_err <= 1'b0;
					if (req_valid && req_ready) begin
						// Zero length is sent as one byte
						left <= (req_len == 11'h000) ? 11'h001 : req_len;
						link.pkt_data <= req_seed - 8'h01;
						link.pkt_crc_err <= req_crc_err;
						sent_this_frame <= 1'b1;
						state <= uio_pkg::UIO_H_SEND;
					end
				end
				uio_pkg::UIO_H_SEND: begin
					link.pkt_valid <= 1'b1;
					link.pkt_data <= link.pkt_data + 8'h01;
					link.pkt_last <= (left == 11'h001);
					left <= left - 11'h001;
					if (left == 11'h001) begin
						state <= uio_pkg::UIO_H_IDLE;
					end
				end
				default: begin
					state <= uio_pkg::UIO_H_IDLE;
				end
			endcase
		end
	end
endmodule // uio_host

// file: verilog/uio_link_if.sv
// Link between USB host side and the isochronous OUT endpoint.
// Assumes both ends run on the same aclk; one byte moves per cycle.
`timescale 1ns/10ps
interface uio_link_if;
	// Start of frame and its number
	logic sof;
	uio_pkg::uio_frame_t frame_num;
	// Packet byte stream, no back-pressure
	logic pkt_valid;
	uio_pkg::uio_byte_t pkt_data;
	logic pkt_last;
	logic pkt_crc_err;

	modport dev (
		input sof,
		input frame_num,
		input pkt_valid,
		input pkt_data,
		input pkt_last,
		input pkt_crc_err
	);

	modport hst (
		output sof,
		output frame_num,
		output pkt_valid,
		output pkt_data,
		output pkt_last,
		output pkt_crc_err
	);
endinterface

// file: verilog/uio_params.svh
// Constants of the isochronous OUT endpoint and its link partner.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef UIO_PARAMS_SVH
`define UIO_PARAMS_SVH

// Register byte offsets on the AXI4-Lite bus
`define UIO_OFS_CTRL 12'h000
`define UIO_OFS_SIZING 12'h004
`define UIO_OFS_MAXP 12'h008
`define UIO_OFS_IRQ_EN 12'h00C
`define UIO_OFS_DATA 12'h010
`define UIO_OFS_COUNT 12'h014
`define UIO_OFS_FRAME_CTL 12'h018
`define UIO_OFS_FRAME_NUM 12'h01C

// Control/status, sizing and frame control field positions
`define UIO_BIT_PKT_READY 0
`define UIO_BIT_OVERRUN 2
`define UIO_BIT_DATA_ERR 3
`define UIO_BIT_DMA_MODE 11
`define UIO_BIT_HS_SUPPRESS 12
`define UIO_BIT_DMA_EN 13
`define UIO_BIT_ISO 14
`define UIO_BIT_DOUBLE_BUF 4
`define UIO_BIT_HIGH_SPEED 0

// Reset values
`define UIO_RST_CTRL 16'h0000
`define UIO_RST_MAXP 11'h000

// Bus answers
`define UIO_RESP_OKAY 2'h0
`define UIO_RESP_SLVERR 2'h2

// Timing: clock period and frame lengths in ns, then frame lengths in cycles
`define UIO_CLK_NS 50
`define UIO_FRAME_NS 1000000
`define UIO_UFRAME_NS 125000
`define UIO_FRAME_CYC (`UIO_FRAME_NS / `UIO_CLK_NS)
`define UIO_UFRAME_CYC (`UIO_UFRAME_NS / `UIO_CLK_NS)

// Sizes
`define UIO_MAX_PKT 1024
`define UIO_STAGE_BYTES 64
`define UIO_EP_NUM 1

`endif

// file: verilog/uio_pkg.sv
// Types shared by both ends of the isochronous OUT link.
// Assumes nothing beyond a SystemVerilog compiler.
package uio_pkg;

	// Partner packet sender states
	typedef enum logic [1:0] {
		UIO_H_IDLE = 2'b01,
		UIO_H_SEND = 2'b10
	} uio_host_state_e;

	typedef logic [7:0] uio_byte_t;
	typedef logic [10:0] uio_frame_t;

endpackage
